// ---- src/scl_pkg.sv ----
// Constants, field layout and mode codes of the serial settings loader.
// Assumes a single core clock; all pin levels are synchronised in the loader.
package scl_pkg;

    // ***********************************************************
    // Settings word layout
    // ***********************************************************
    localparam int          SET_W        = 39;
    localparam int          OPT_W        = 14;
    localparam int          LIM_W        = 5;
    localparam int          NUM_LIM      = 4;
    localparam int          TONE_POS     = 38;
    localparam int          EOL_POS      = 37;
    localparam int          LBH_POS      = 36;
    localparam int          HUSH_POS     = 35;
    localparam int          DRIFT_POS    = 34;
    localparam int          LB_LSB       = 31;
    localparam int          IRC_LSB      = 29;
    localparam int          IT_LSB       = 27;
    localparam int          GAIN_LSB     = 25;
    localparam int          NL_LSB       = 20;
    localparam int          HYL_LSB      = 15;
    localparam int          HUL_LSB      = 10;
    localparam int          CTL_LSB      = 5;
    localparam int          BASE_LSB     = 0;
    localparam logic [38:0] SETTINGS_RST = 39'h00_0000_0000;
    localparam logic [4:0]  LIM_RST      = 5'h00;

    // ***********************************************************
    // Pin synchroniser lanes
    // ***********************************************************
    localparam int PIN_W     = 5;
    localparam int PIN_DATA  = 0;
    localparam int PIN_BOOST = 1;
    localparam int PIN_TEN   = 2;
    localparam int PIN_FEED  = 3;
    localparam int PIN_IO    = 4;

    // ***********************************************************
    // Test modes
    // ***********************************************************
    typedef enum logic [3:0] {
        option_load_mode    = 4'h0,
        norm_lim_set        = 4'h1,
        hyst_lim_set        = 4'h2,
        hush_lim_set        = 4'h3,
        ctest_lim_set       = 4'h4,
        baseline_store_mode = 4'h5,
        full_serial_mode    = 4'h6,
        norm_lim_check      = 4'h7,
        hyst_lim_check      = 4'h8,
        hush_lim_check      = 4'h9,
        ctest_lim_check     = 4'ha,
        horn_test_mode      = 4'hb
    } scl_mode_t;

endpackage : scl_pkg

// ---- src/scl_pin_sync.sv ----
// Two-stage synchroniser with rising-edge detect for a group of pins.
// Assumes pins are asynchronous to core_clk; edges are seen after stage two.
`timescale 1ns/1ns
module scl_pin_sync #(
    parameter int W = 5
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out,
    output logic      [W-1:0] rise_out
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // First stage feeds only the second
    assign level_out = sync_q;
    assign rise_out  = sync_q & ~prev_q;

endmodule : scl_pin_sync

// ---- src/scl_loader.sv ----
// Serial configuration and calibration loader of the detector controller.
// Assumes pins come straight from pads and the analog levels are digitised
// on core_clk. Storage write is modelled as a register update.
// Functional notes
// - Set modes: output high when gain below integrator
// - Check modes: output high when measurement exceeds limit
// - Latch limits in T1-T4, store in T5
// - One data bit shifted per feed clock
// - Option mode loads only bits 25 to 38
// - Full serial mode loads all 39 bits
// - Upper option fields at fixed bit positions
// - Test clock advances mode while enabled, up to horn test mode (T11)
// - Only boost-level swings count as mode clocks
// - Battery trip code decodes bit-reversed into the rank
`timescale 1ns/1ns
module scl_loader
    import scl_pkg::*;
(
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic                   test_data_pin,
    input  wire logic                   test_boost_pin,
    input  wire logic                   test_enable_pin,
    input  wire logic                   feed_pin,
    input  wire logic                   io_pin,
    input  wire logic [scl_pkg::LIM_W-1:0] gamp_level,
    input  wire logic [scl_pkg::LIM_W-1:0] integrator_output,
    output logic                        horn_brightness_pin,
    output logic                        smoke_compare_out,
    output logic                        limit_compare_out,
    output scl_pkg::scl_mode_t          test_mode,
    output logic                        tone_select,
    output logic                        end_life_enable,
    output logic                        low_batt_hush_enable,
    output logic                        hush_option,
    output logic                        drift_enable,
    output logic [2:0]                  low_batt_trip,
    output logic [2:0]                  low_batt_rank,
    output logic [1:0]                  emitter_current,
    output logic [1:0]                  integration_time,
    output logic [1:0]                  photo_gain,
    output logic [scl_pkg::LIM_W-1:0]   normal_limit,
    output logic [scl_pkg::LIM_W-1:0]   hysteresis_limit,
    output logic [scl_pkg::LIM_W-1:0]   hush_limit,
    output logic [scl_pkg::LIM_W-1:0]   chamber_test_limit,
    output logic [scl_pkg::LIM_W-1:0]   drift_baseline
);
    import scl_pkg::*;

    // ***********************************************************
    // Pin synchronisation
    // ***********************************************************
    logic [PIN_W-1:0] pin_lvl;
    logic [PIN_W-1:0] pin_rise;

    scl_pin_sync #(.W(PIN_W)) u_sync (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .pin_in    ({io_pin, feed_pin, test_enable_pin, test_boost_pin, test_data_pin}),
        .level_out (pin_lvl),
        .rise_out  (pin_rise)
    );

    wire       data_bit    = pin_lvl[PIN_DATA];
    wire       test_active = pin_lvl[PIN_TEN];
    wire       boost_rise  = pin_rise[PIN_BOOST];
    wire       feed_rise   = pin_rise[PIN_FEED];
    wire       io_rise     = pin_rise[PIN_IO];

    // ***********************************************************
    // Mode decode
    // ***********************************************************
    scl_mode_t mode_q;
    scl_mode_t mode_d;
    wire       mode_step   = test_active && boost_rise && (mode_q != horn_test_mode);
    wire       in_t0       = test_active && (mode_q == option_load_mode);
    wire       in_t5       = test_active && (mode_q == baseline_store_mode);
    wire       in_t6       = test_active && (mode_q == full_serial_mode);
    wire       in_set      = test_active && (mode_q >= norm_lim_set)
                             && (mode_q <= baseline_store_mode);
    wire       in_latch    = in_set && !in_t5;
    wire       in_check    = test_active && (mode_q >= norm_lim_check)
                             && (mode_q <= ctest_lim_check);
    wire       shift_en    = feed_rise && (in_t0 || in_t6);
    wire       program_enable = io_rise;
    wire       latch_limit_in = io_rise && in_latch;
    wire       measure_enable = feed_rise && (in_t5 || in_check);
    wire       enter_t6    = mode_step && (mode_q == baseline_store_mode);
    wire [1:0] latch_idx   = 2'(mode_q - norm_lim_set);
    wire [1:0] check_idx   = 2'(mode_q - norm_lim_check);

    // Test clock only from the boost comparator, never the data level
    assign mode_d = !test_active ? option_load_mode
                  : mode_step    ? scl_mode_t'(mode_q + 4'h1)
                  : mode_q;

    // ***********************************************************
    // State registers
    // ***********************************************************
    logic [SET_W-1:0] shift_q;
    logic [SET_W-1:0] settings_q;
    logic [SET_W-1:0] settings_d;
    logic [LIM_W-1:0] lim_q [NUM_LIM];
    logic [LIM_W-1:0] meas_q;
    logic             meas_valid_q;
    logic             smk_q;
    logic             lcmp_q;
    logic             horn_q;

    wire [4*LIM_W-1:0] lim_flat = {lim_q[0], lim_q[1], lim_q[2], lim_q[3]};
    wire [LIM_W-1:0]   sel_lim  = settings_q[NL_LSB - LIM_W*check_idx +: LIM_W];
    wire               smk_d    = gamp_level < integrator_output;
    wire               lcmp_d   = meas_valid_q && (meas_q > sel_lim);

    // Storage write on program enable, per mode
    assign settings_d =
        (program_enable && in_t0) ? {shift_q[OPT_W-1:0], settings_q[GAIN_LSB-1:0]}
      : (program_enable && in_t6) ? shift_q
      : (program_enable && in_t5) ? {settings_q[SET_W-1:GAIN_LSB], lim_flat, meas_q}
      : settings_q;

    wire horn_d = in_set   ? smk_d
                : in_check ? lcmp_d
                : in_t6    ? shift_q[SET_W-1]
                : 1'b0;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q     <= option_load_mode;
            settings_q <= SETTINGS_RST;
            shift_q    <= SETTINGS_RST;
        end else begin
            mode_q     <= mode_d;
            settings_q <= settings_d;
            // Read-back loads the stored word so T6 shifts it out MSB first
            if (enter_t6)
                shift_q <= settings_q;
            else if (shift_en)
                shift_q <= {shift_q[SET_W-2:0], data_bit};
        end
    end

    // Measurement is stale once the mode moves on
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            meas_q       <= LIM_RST;
            meas_valid_q <= 1'b0;
        end else if (mode_step || !test_active) begin
            meas_valid_q <= 1'b0;
        end else if (measure_enable) begin
            meas_q       <= gamp_level;
            meas_valid_q <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            smk_q  <= 1'b0;
            lcmp_q <= 1'b0;
            horn_q <= 1'b0;
        end else begin
            smk_q  <= smk_d;
            lcmp_q <= lcmp_d;
            horn_q <= horn_d;
        end
    end

    // ***********************************************************
    // Limit latches, one per limit set mode T1-T4
    // ***********************************************************
    for (genvar i = 0; i < NUM_LIM; i++) begin : g_lim
        always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst)
                lim_q[i] <= LIM_RST;
            else if (latch_limit_in && latch_idx == 2'(i))
                lim_q[i] <= gamp_level;
        end
    end

    // ***********************************************************
    // Outputs
    // ***********************************************************
    assign horn_brightness_pin  = horn_q;
    assign smoke_compare_out    = smk_q;
    assign limit_compare_out    = lcmp_q;
    assign test_mode            = mode_q;
    assign tone_select          = settings_q[TONE_POS];
    assign end_life_enable      = settings_q[EOL_POS];
    assign low_batt_hush_enable = settings_q[LBH_POS];
    assign hush_option          = settings_q[HUSH_POS];
    assign drift_enable         = settings_q[DRIFT_POS];
    assign low_batt_trip        = settings_q[LB_LSB +: 3];
    assign emitter_current      = settings_q[IRC_LSB +: 2];
    assign integration_time     = settings_q[IT_LSB +: 2];
    assign photo_gain           = settings_q[GAIN_LSB +: 2];
    // Trip code is bit-reversed against voltage rank
    assign low_batt_rank        = {low_batt_trip[0], low_batt_trip[1], low_batt_trip[2]};
    assign normal_limit         = settings_q[NL_LSB +: LIM_W];
    assign hysteresis_limit     = settings_q[HYL_LSB +: LIM_W];
    assign hush_limit           = settings_q[HUL_LSB +: LIM_W];
    assign chamber_test_limit   = settings_q[CTL_LSB +: LIM_W];
    assign drift_baseline       = settings_q[BASE_LSB +: LIM_W];

    // ***********************************************************
    // Assertions
    // ***********************************************************
    sequence t6_store_s;
        program_enable && in_t6;
    endsequence

    sequence t0_store_s;
        program_enable && in_t0;
    endsequence

    smoke_cmp_a: assert property (@(posedge core_clk) disable iff (!nrst)
        in_set |=> horn_brightness_pin == $past(gamp_level < integrator_output))
        else $error("smoke compare output wrong");

    limit_cmp_a: assert property (@(posedge core_clk) disable iff (!nrst)
        in_check && !meas_valid_q |=> !limit_compare_out && !horn_brightness_pin)
        else $error("limit compare high before measurement");

    limit_val_a: assert property (@(posedge core_clk) disable iff (!nrst)
        in_check && measure_enable && !mode_step ##1 in_check
        |=> limit_compare_out == ($past(meas_q) > $past(sel_lim)))
        else $error("limit compare value wrong");

    latch_lim_a: assert property (@(posedge core_clk) disable iff (!nrst)
        latch_limit_in |=> lim_q[$past(latch_idx)] == $past(gamp_level))
        else $error("limit not latched");

    store_lim_a: assert property (@(posedge core_clk) disable iff (!nrst)
        program_enable && in_t5 |=> settings_q[24:5] == $past(lim_flat))
        else $error("limits not stored");

    opt_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
        t0_store_s |=> settings_q[38:25] == $past(shift_q[13:0])
                       && $stable(settings_q[24:0]))
        else $error("option load wrong");

    full_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
        t6_store_s |=> settings_q == $past(shift_q))
        else $error("full load wrong");

    field_pos_a: assert property (@(posedge core_clk) disable iff (!nrst)
        t6_store_s |=> tone_select == $past(shift_q[38])
                       && photo_gain == $past(shift_q[26:25])
                       && low_batt_trip == $past(shift_q[33:31]))
        else $error("field placement wrong");

    shift_in_a: assert property (@(posedge core_clk) disable iff (!nrst)
        shift_en && !enter_t6 |=> shift_q == {$past(shift_q[37:0]), $past(data_bit)})
        else $error("shift order wrong");

    mode_step_a: assert property (@(posedge core_clk) disable iff (!nrst)
        mode_step |=> test_mode == scl_mode_t'($past(mode_q) + 4'h1))
        else $error("mode did not advance");

    mode_hold_a: assert property (@(posedge core_clk) disable iff (!nrst)
        test_active && !boost_rise |=> $stable(test_mode))
        else $error("mode moved without boost clock");

    lb_rank_a: assert property (@(posedge core_clk) disable iff (!nrst)
        low_batt_trip == 3'h4 |-> low_batt_rank == 3'h1)
        else $error("battery trip rank wrong");

endmodule : scl_loader

// ---- dv/scl_station.sv ----
// Programming station model driving the test, enable, feed and io pins.
// Assumes one task call at a time; pins change on the core_clk fall.
`timescale 1ns/1ns
module scl_station (
    input  wire logic core_clk,
    output logic      test_data_pin,
    output logic      test_boost_pin,
    output logic      test_enable_pin,
    output logic      feed_pin,
    output logic      io_pin
);
    // ****************************************
    // Pin drivers
    // ****************************************
    initial begin
        {test_data_pin, test_boost_pin, test_enable_pin} = 3'b000;
        {feed_pin, io_pin} = 2'b00;
    end

    // Half of the 80 ns link period
    task automatic half_period();
        repeat (4) @(negedge core_clk);
    endtask : half_period

    task automatic set_enable(input logic v);
        @(negedge core_clk);
        test_enable_pin = v;
        half_period();
    endtask : set_enable

    // 0 feed, 1 io, 2 boost, 3 data only
    task automatic pulse(input int pin);
        @(negedge core_clk);
        case (pin)
            0: feed_pin = 1'b1;
            1: io_pin = 1'b1;
            3: test_data_pin = 1'b1;
            default: begin
                // Boost swing also lifts the logic-level comparator
                test_boost_pin = 1'b1;
                test_data_pin  = 1'b1;
            end
        endcase
        half_period();
        {feed_pin, io_pin, test_boost_pin, test_data_pin} = 4'h0;
        half_period();
    endtask : pulse

    task automatic shift(input logic [38:0] w, input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge core_clk);
            test_data_pin = w[38-i];
            pulse(0);
        end
    endtask : shift
endmodule : scl_station

// ---- dv/scl_loader_tb.sv ----
// Self-checking bench of the settings loader with a station model.
// Assumes the loader of src/ and its package; run is under a thousand cycles.
`timescale 1ns/1ns
module scl_loader_tb;
    import scl_pkg::*;
    typedef struct {
        string       name;
        int          sel;
        logic [38:0] exp;
    } scl_note_t;

    // ****************************************
    // Signals
    // ****************************************
    logic        core_clk, nrst;
    logic [4:0]  gamp_level, integrator_output;
    wire logic   test_data_pin, test_boost_pin, test_enable_pin, feed_pin, io_pin;
    logic        horn_brightness_pin, smoke_compare_out, limit_compare_out;
    scl_mode_t   test_mode;
    logic        tone_select, end_life_enable, low_batt_hush_enable, hush_option;
    logic        drift_enable;
    logic [2:0]  low_batt_trip, low_batt_rank;
    logic [1:0]  emitter_current, integration_time, photo_gain;
    logic [4:0]  normal_limit, hysteresis_limit, hush_limit, chamber_test_limit;
    logic [4:0]  drift_baseline;
    wire  [38:0] settings_obs;
    scl_note_t   notes[$];
    scl_note_t   cur;
    event        result_ev;
    int          mismatches = 0;
    int          checks_done = 0;

    assign settings_obs = {tone_select, end_life_enable, low_batt_hush_enable,
        hush_option, drift_enable, low_batt_trip, emitter_current, integration_time,
        photo_gain, normal_limit, hysteresis_limit, hush_limit, chamber_test_limit,
        drift_baseline};

    scl_station u_scl_station (
        .core_clk             (core_clk),
        .test_data_pin        (test_data_pin),
        .test_boost_pin       (test_boost_pin),
        .test_enable_pin      (test_enable_pin),
        .feed_pin             (feed_pin),
        .io_pin               (io_pin)
    );
    scl_loader u_scl_loader (
        .core_clk             (core_clk),
        .nrst                 (nrst),
        .test_data_pin        (test_data_pin),
        .test_boost_pin       (test_boost_pin),
        .test_enable_pin      (test_enable_pin),
        .feed_pin             (feed_pin),
        .io_pin               (io_pin),
        .gamp_level           (gamp_level),
        .integrator_output    (integrator_output),
        .horn_brightness_pin  (horn_brightness_pin),
        .smoke_compare_out    (smoke_compare_out),
        .limit_compare_out    (limit_compare_out),
        .test_mode            (test_mode),
        .tone_select          (tone_select),
        .end_life_enable      (end_life_enable),
        .low_batt_hush_enable (low_batt_hush_enable),
        .hush_option          (hush_option),
        .drift_enable         (drift_enable),
        .low_batt_trip        (low_batt_trip),
        .low_batt_rank        (low_batt_rank),
        .emitter_current      (emitter_current),
        .integration_time     (integration_time),
        .photo_gain           (photo_gain),
        .normal_limit         (normal_limit),
        .hysteresis_limit     (hysteresis_limit),
        .hush_limit           (hush_limit),
        .chamber_test_limit   (chamber_test_limit),
        .drift_baseline       (drift_baseline)
    );

    // ****************************************
    // Checking
    // ****************************************
    function automatic logic [38:0] obs(input int sel);
        case (sel)
            0: return settings_obs;
            1: return 39'(test_mode);
            2: return 39'(horn_brightness_pin);
            3: return 39'(limit_compare_out);
            4: return 39'(low_batt_rank);
            default: return 39'(smoke_compare_out);
        endcase
    endfunction : obs

    function automatic logic [2:0] rank(input logic [38:0] w);
        return {w[31], w[32], w[33]};
    endfunction : rank

    task automatic check(input string name, input logic [38:0] seen, input logic [38:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic note(input string name, input int sel, input logic [38:0] exp);
        notes.push_back('{name, sel, exp});
        -> result_ev;
    endtask : note

    initial forever begin
        @(result_ev);
        while (notes.size() > 0) begin
            cur = notes.pop_front();
            check(cur.name, obs(cur.sel), cur.exp);
        end
    end

    task automatic end_sim();
        #1;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    // ****************************************
    // Stimulus
    // ****************************************
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Whole sequence needs about 8 us
    initial begin
        #200000;
        mismatches++;
        end_sim();
    end

    initial begin
        logic [38:0] exp, w, lat;
        nrst = 1'b0;
        gamp_level = 5'h00;
        integrator_output = 5'h00;
        lat = 39'h0;
        repeat (12) @(negedge core_clk);
        nrst = 1'b1;
        void'($urandom(63072));
        note("settings", 0, 39'h0);
        note("mode", 1, 39'h0);
        u_scl_station.set_enable(1'b1);
        exp = {14'($urandom), 25'h0};
        exp[34] = 1'b0;
        u_scl_station.shift(exp, 14);
        u_scl_station.pulse(1);
        note("options", 0, exp);
        note("rank", 4, 39'(rank(exp)));
        u_scl_station.pulse(3);
        note("mode", 1, 39'h0);
        // Set steps are walked straight through to limit heating
        for (int m = 1; m <= 4; m++) begin
            u_scl_station.pulse(2);
            note("mode", 1, 39'(m));
            gamp_level = 5'($urandom);
            integrator_output = 5'($urandom);
            if (gamp_level == integrator_output) begin
                integrator_output = gamp_level ^ 5'h01;
            end
            repeat (4) @(negedge core_clk);
            note("smoke", 2, 39'(gamp_level < integrator_output));
            note("smoke_out", 5, 39'(gamp_level < integrator_output));
            u_scl_station.pulse(1);
            lat[24-5*(m-1) -: 5] = gamp_level;
            note("held", 0, exp);
        end
        u_scl_station.pulse(2);
        gamp_level = 5'($urandom);
        u_scl_station.pulse(0);
        lat[4:0] = gamp_level;
        u_scl_station.pulse(1);
        exp[24:0] = lat[24:0];
        note("store", 0, exp);
        u_scl_station.pulse(2);
        note("serial", 2, 39'(exp[38]));
        w = 39'({$urandom, $urandom});
        w[34] = 1'b0;
        w[24:20] = 5'(1 + $urandom % 30);
        u_scl_station.shift(w, 39);
        u_scl_station.pulse(1);
        note("full", 0, w);
        note("rank", 4, 39'(rank(w)));
        u_scl_station.pulse(2);
        note("limit", 3, 39'h0);
        for (int k = 0; k < 3; k++) begin
            gamp_level = w[24:20] + 5'(k) - 5'h01;
            u_scl_station.pulse(0);
            note("limit", 3, 39'(k == 2));
        end
        u_scl_station.pulse(2);
        note("limit", 3, 39'h0);
        for (int m = 9; m <= 12; m++) begin
            u_scl_station.pulse(2);
            note("mode", 1, 39'((m > 11) ? 11 : m));
        end
        u_scl_station.set_enable(1'b0);
        note("mode", 1, 39'h0);
        // Mid-run reset wipes the stored word and the mode
        nrst = 1'b0;
        repeat (2) @(negedge core_clk);
        note("reset", 0, 39'h0);
        note("reset_horn", 2, 39'h0);
        nrst = 1'b1;
        repeat (4) @(negedge core_clk);
        note("mode", 1, 39'h0);
        end_sim();
    end
endmodule : scl_loader_tb
